// ---- hw/occ_output1_clock_control.sv ----
// Control logic for clock output one: control register, source mux, polarity and power down.
// Overview of operation
// - Power-down bit one turns output driver off.
// - Integer-mode bit picks integer or fractional division.
// - Divider source bit picks pll_a_a or pll_b_b.
// - Invert bit drives the output inverted.
// - Source 00 routes crystal oscillator straight out.
// - Source 01 routes external clock input out.
// - Source 11 drives output from output divider.
// - Drive field sets 2, 4, 6 or 8 mA.
`timescale 1ns/1ps
module occ_output1_clock_control
  import occ_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Avalon-MM slave.
  input wire logic [OCC_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [OCC_DATA_W-1:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [OCC_DATA_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Raw clocks from the oscillator, input pin, PLLs and output divider.
  input wire logic xtal_clk_i,
  input wire logic external_clock_input_i,
  input wire logic pll_a_a_clk_i,
  input wire logic pll_b_b_clk_i,
  input wire logic divider_clk_i,
  // Controls for the output divider and driver.
  output logic divider_ref_clk_o,
  output logic out1_divider_integer_mode_o,
  output logic out1_divider_pll_select_o,
  output logic out1_power_down_o,
  output logic [1:0] out1_drive_strength_o,
  output logic clock_output_one_o
);

  function automatic logic occ_hit(input logic [OCC_ADDR_W-1:0] addr, input logic [OCC_ADDR_W-1:0] idx);
    occ_hit = (addr == {idx[OCC_ADDR_W-3:0], OCC_IDX_PAD});
  endfunction

  logic [OCC_CTRL_W-1:0] ctrl_ff;
  logic [OCC_NSRC-1:0] sync1_ff;
  logic [OCC_NSRC-1:0] sync2_ff;
  logic waitreq_ff;
  logic [OCC_DATA_W-1:0] rdata_ff;
  logic out_clk_ff;
  logic div_ref_ff;
  logic int_mode_ff;
  logic pll_sel_ff;
  logic pdn_ff;
  logic [1:0] drv_ff;
  logic nxt_out_clk;
  logic src_level;
  logic commit;
  logic [OCC_DATA_W-1:0] nxt_rdata;

  // An access completes on the edge where waitrequest is seen low.
  assign commit = (avs_read_i | avs_write_i) & ~waitreq_ff;

  // One wait state gives a registered read path at the full clock rate.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      waitreq_ff <= 1'b1;
    end else if (commit) begin
      waitreq_ff <= 1'b1;
    end else if (avs_read_i | avs_write_i) begin
      waitreq_ff <= 1'b0;
    end
  end

  // Only byte lane zero holds control bits; other lanes are ignored.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_ff <= OCC_CTRL_RST;
    end else if (commit && avs_write_i && avs_byteenable_i[OCC_BE_W] && occ_hit(avs_address_i, OCC_CTRL_IDX)) begin
      ctrl_ff <= avs_writedata_i[OCC_CTRL_W-1:0];
    end
  end

  always_comb begin
    nxt_rdata = '0;
    if (occ_hit(avs_address_i, OCC_CTRL_IDX)) begin
      nxt_rdata[OCC_CTRL_W-1:0] = ctrl_ff;
    end else if (occ_hit(avs_address_i, OCC_STAT_IDX)) begin
      nxt_rdata[OCC_STAT_RUN] = ~ctrl_ff[OCC_PDN_BIT] & (ctrl_ff[OCC_SRC_HI:OCC_SRC_LO] != OCC_SRC_RSVD);
      nxt_rdata[OCC_STAT_RSVD] = (ctrl_ff[OCC_SRC_HI:OCC_SRC_LO] == OCC_SRC_RSVD);
      nxt_rdata[OCC_STAT_LVL] = out_clk_ff;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_ff <= '0;
    end else if (avs_read_i && waitreq_ff) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Clocks from other domains pass two flip-flops before the mux reads them.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= {divider_clk_i, pll_b_b_clk_i, pll_a_a_clk_i, external_clock_input_i, xtal_clk_i};
      sync2_ff <= sync1_ff;
    end
  end

  always_comb begin
    case (ctrl_ff[OCC_SRC_HI:OCC_SRC_LO])
      OCC_SRC_XTAL: src_level = sync2_ff[OCC_IN_XTAL];
      OCC_SRC_EXT: src_level = sync2_ff[OCC_IN_EXT];
      OCC_SRC_DIV: src_level = sync2_ff[OCC_IN_DIV];
      default: src_level = 1'b0;
    endcase
    // A reserved source holds the pin at the invert bit level rather than passing an undefined clock.
    nxt_out_clk = ~ctrl_ff[OCC_PDN_BIT] & (src_level ^ ctrl_ff[OCC_INV_BIT]);
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      out_clk_ff <= 1'b0;
      pdn_ff <= OCC_CTRL_RST[OCC_PDN_BIT];
    end else begin
      out_clk_ff <= nxt_out_clk;
      pdn_ff <= ctrl_ff[OCC_PDN_BIT];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_ref_ff <= 1'b0;
      pll_sel_ff <= OCC_CTRL_RST[OCC_PLL_BIT];
      int_mode_ff <= OCC_CTRL_RST[OCC_INT_BIT];
      drv_ff <= OCC_CTRL_RST[OCC_DRV_HI:OCC_DRV_LO];
    end else begin
      div_ref_ff <= ctrl_ff[OCC_PLL_BIT] ? sync2_ff[OCC_IN_PLL_B_B] : sync2_ff[OCC_IN_PLL_A_A];
      pll_sel_ff <= ctrl_ff[OCC_PLL_BIT];
      // Integer mode is passed as written; delay offset compatibility is left to software.
      int_mode_ff <= ctrl_ff[OCC_INT_BIT];
      drv_ff <= ctrl_ff[OCC_DRV_HI:OCC_DRV_LO];
    end
  end

  assign avs_readdata_o = rdata_ff;
  assign avs_waitrequest_o = waitreq_ff;
  assign clock_output_one_o = out_clk_ff;
  assign divider_ref_clk_o = div_ref_ff;
  assign out1_divider_integer_mode_o = int_mode_ff;
  assign out1_divider_pll_select_o = pll_sel_ff;
  assign out1_power_down_o = pdn_ff;
  assign out1_drive_strength_o = drv_ff;

  default clocking occ_cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rstn_i);

  a_pdn_quiets_out: assert property (ctrl_ff[OCC_PDN_BIT] |=> !clock_output_one_o && out1_power_down_o)
    else $error("Powered down output is not quiet.");
  a_int_mode_write: assert property (commit && avs_write_i && avs_byteenable_i[OCC_BE_W]
      && occ_hit(avs_address_i, OCC_CTRL_IDX) |=> ##1 out1_divider_integer_mode_o == $past(avs_writedata_i[OCC_INT_BIT], 2))
    else $error("Integer mode does not follow the written bit.");
  a_pll_ref_mux: assert property (##1 divider_ref_clk_o == ($past(ctrl_ff[OCC_PLL_BIT]) ?
      $past(sync2_ff[OCC_IN_PLL_B_B]) : $past(sync2_ff[OCC_IN_PLL_A_A])))
    else $error("Divider reference comes from the wrong PLL.");
  a_invert_path: assert property (!ctrl_ff[OCC_PDN_BIT] && ctrl_ff[OCC_SRC_HI:OCC_SRC_LO] == OCC_SRC_XTAL
      && ctrl_ff[OCC_INV_BIT] |=> clock_output_one_o == !$past(sync2_ff[OCC_IN_XTAL]))
    else $error("Inverted output has wrong polarity.");
  a_xtal_path: assert property (!ctrl_ff[OCC_PDN_BIT] && !ctrl_ff[OCC_INV_BIT]
      && ctrl_ff[OCC_SRC_HI:OCC_SRC_LO] == OCC_SRC_XTAL |=> clock_output_one_o == $past(sync2_ff[OCC_IN_XTAL]))
    else $error("Crystal source not routed to output.");
  a_ext_path: assert property (!ctrl_ff[OCC_PDN_BIT] && !ctrl_ff[OCC_INV_BIT]
      && ctrl_ff[OCC_SRC_HI:OCC_SRC_LO] == OCC_SRC_EXT |=> clock_output_one_o == $past(sync2_ff[OCC_IN_EXT]))
    else $error("External clock not routed to output.");
  a_div_path: assert property (!ctrl_ff[OCC_PDN_BIT] && !ctrl_ff[OCC_INV_BIT]
      && ctrl_ff[OCC_SRC_HI:OCC_SRC_LO] == OCC_SRC_DIV |=> clock_output_one_o == $past(sync2_ff[OCC_IN_DIV]))
    else $error("Divider clock not routed to output.");
  a_drive_write: assert property (commit && avs_write_i && avs_byteenable_i[OCC_BE_W]
      && occ_hit(avs_address_i, OCC_CTRL_IDX) |=> ##1 out1_drive_strength_o == $past(avs_writedata_i[OCC_DRV_HI:OCC_DRV_LO], 2))
    else $error("Drive strength does not follow the written field.");
  a_ctrl_readback: assert property (avs_read_i && !avs_waitrequest_o && occ_hit(avs_address_i, OCC_CTRL_IDX)
      |-> avs_readdata_o == {{(OCC_DATA_W-OCC_CTRL_W){1'b0}}, ctrl_ff})
    else $error("Control register read back wrong.");

  // The handshake has exactly one wait state, so a master that waits for it never stalls twice.
  a_wait_answers: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("Request was not answered after one wait state.");
  a_wait_one_cycle: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("Waitrequest stayed low for more than one cycle.");
  a_wait_idle: assert property (!avs_read_i && !avs_write_i && avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("Waitrequest dropped with no request.");

  // Field outputs follow a write two edges later: one edge into the register, one into the output flop.
  a_pdn_write: assert property (commit && avs_write_i && avs_byteenable_i[OCC_BE_W]
      && occ_hit(avs_address_i, OCC_CTRL_IDX) |=> ##1 out1_power_down_o == $past(avs_writedata_i[OCC_PDN_BIT], 2))
    else $error("Power down does not follow the written bit.");
  a_pll_sel_write: assert property (commit && avs_write_i && avs_byteenable_i[OCC_BE_W]
      && occ_hit(avs_address_i, OCC_CTRL_IDX) |=> ##1 out1_divider_pll_select_o == $past(avs_writedata_i[OCC_PLL_BIT], 2))
    else $error("Divider source select does not follow the written bit.");
  a_ctrl_unchanged: assert property (commit && avs_write_i
      && !(avs_byteenable_i[OCC_BE_W] && occ_hit(avs_address_i, OCC_CTRL_IDX)) |=> $stable(ctrl_ff))
    else $error("Control register changed on an ignored write.");
  a_status_read: assert property (avs_read_i && !avs_waitrequest_o && occ_hit(avs_address_i, OCC_STAT_IDX)
      |-> avs_readdata_o[OCC_STAT_RUN] == (!ctrl_ff[OCC_PDN_BIT] && ctrl_ff[OCC_SRC_HI:OCC_SRC_LO] != OCC_SRC_RSVD)
      && avs_readdata_o[OCC_STAT_LVL] == $past(clock_output_one_o))
    else $error("Status register read back wrong.");
  a_unmapped_zero: assert property (avs_read_i && !avs_waitrequest_o && !occ_hit(avs_address_i, OCC_CTRL_IDX)
      && !occ_hit(avs_address_i, OCC_STAT_IDX) |-> avs_readdata_o == '0)
    else $error("Unmapped read did not return zero.");

  c_ctrl_write: cover property (commit && avs_write_i && occ_hit(avs_address_i, OCC_CTRL_IDX));
  c_status_read: cover property (commit && avs_read_i && occ_hit(avs_address_i, OCC_STAT_IDX));
  c_ctrl_read: cover property (commit && avs_read_i && occ_hit(avs_address_i, OCC_CTRL_IDX));
  c_div_running: cover property (!ctrl_ff[OCC_PDN_BIT] && ctrl_ff[OCC_SRC_HI:OCC_SRC_LO] == OCC_SRC_DIV ##1 clock_output_one_o);
  c_drive_max: cover property (out1_drive_strength_o == OCC_DRV_8MA);

endmodule

// ---- hw/occ_pkg.sv ----
// Package with the register map, field layout and bus constants of the output one clock control block.
package occ_pkg;
  localparam int OCC_DATA_W = 32;
  localparam int OCC_ADDR_W = 8;
  localparam int OCC_CTRL_W = 8;
  localparam int OCC_NSRC = 5;
  // Register indexes; the byte address is four times the index.
  localparam logic [OCC_ADDR_W-1:0] OCC_CTRL_IDX = 8'h11;
  localparam logic [OCC_ADDR_W-1:0] OCC_STAT_IDX = 8'h12;
  localparam logic [1:0] OCC_IDX_PAD = 2'h0;
  // Control register fields.
  localparam int OCC_PDN_BIT = 7;
  localparam int OCC_INT_BIT = 6;
  localparam int OCC_PLL_BIT = 5;
  localparam int OCC_INV_BIT = 4;
  localparam int OCC_SRC_HI = 3;
  localparam int OCC_SRC_LO = 2;
  localparam int OCC_DRV_HI = 1;
  localparam int OCC_DRV_LO = 0;
  localparam logic [OCC_CTRL_W-1:0] OCC_CTRL_RST = 8'h80;
  // Output source encodings.
  localparam logic [1:0] OCC_SRC_XTAL = 2'h0;
  localparam logic [1:0] OCC_SRC_EXT = 2'h1;
  localparam logic [1:0] OCC_SRC_RSVD = 2'h2;
  localparam logic [1:0] OCC_SRC_DIV = 2'h3;
  // Drive strength codes: 2, 4, 6 and 8 mA.
  localparam logic [1:0] OCC_DRV_2MA = 2'h0;
  localparam logic [1:0] OCC_DRV_8MA = 2'h3;
  // Positions of the raw clock inputs in the synchroniser vector.
  localparam int OCC_IN_XTAL = 0;
  localparam int OCC_IN_EXT = 1;
  localparam int OCC_IN_PLL_A_A = 2;
  localparam int OCC_IN_PLL_B_B = 3;
  localparam int OCC_IN_DIV = 4;
  // Status register fields.
  localparam int OCC_STAT_RUN = 0;
  localparam int OCC_STAT_RSVD = 1;
  localparam int OCC_STAT_LVL = 2;
  localparam logic [1:0] OCC_BE_W = 2'h0;
endpackage

// ---- verification/occ_output1_clock_control_test.sv ----
// Self-checking testbench for the output one clock control block.
`timescale 1ns/1ps
module occ_output1_clock_control_test
  import occ_pkg::*;
;
  logic sys_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] adr = 8'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] be = 4'hf;
  logic [31:0] rdat;
  logic wait_o;
  logic [4:0] raw = 5'h0;
  logic [4:0] hist [0:3];
  logic [31:0] seed_r = 32'h2754;
  logic ref_o, int_o, pll_o, pdn_o, out_o;
  logic [1:0] drv_o;
  logic [7:0] ctl;
  logic [31:0] q;
  logic mon_on = 1'b0;
  int n_fail = 0;
  int samples_checked = 0;
  logic [7:0] corner [0:7] = '{8'h00, 8'h05, 8'h1e, 8'h6f, 8'h3d, 8'hb2, 8'h4c, 8'h97};

  always #2.5 sys_clk_i = ~sys_clk_i;

  occ_output1_clock_control DUT (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(be), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wait_o), .xtal_clk_i(raw[OCC_IN_XTAL]), .external_clock_input_i(raw[OCC_IN_EXT]),
    .pll_a_a_clk_i(raw[OCC_IN_PLL_A_A]), .pll_b_b_clk_i(raw[OCC_IN_PLL_B_B]), .divider_clk_i(raw[OCC_IN_DIV]),
    .divider_ref_clk_o(ref_o), .out1_divider_integer_mode_o(int_o), .out1_divider_pll_select_o(pll_o),
    .out1_power_down_o(pdn_o), .out1_drive_strength_o(drv_o), .clock_output_one_o(out_o));

  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Power down holds the pin low; a reserved source gives the invert bit level, but the stimulus never selects it.
  function automatic logic exp_out(input logic [7:0] c, input logic [4:0] r);
    if (c[7] || c[3:2] == OCC_SRC_RSVD) return 1'b0;
    return (c[3:2] == OCC_SRC_XTAL ? r[OCC_IN_XTAL] : c[3:2] == OCC_SRC_EXT ? r[OCC_IN_EXT] : r[OCC_IN_DIV]) ^ c[4];
  endfunction

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // The request is held until waitrequest is seen low at a rising edge; the wait is bounded.
  task automatic bus_op(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] b,
                        output logic [31:0] r);
    int n;
    @(posedge sys_clk_i);
    adr <= a;
    wdat <= d;
    be <= b;
    wr <= w;
    rd <= ~w;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (wait_o !== 1'b0 && n < 50);
    r = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    if (n >= 50) begin
      n_fail++;
      complete_run();
    end
  endtask

  // Random levels on every raw clock keep all mux legs busy.
  always @(posedge sys_clk_i) begin
    seed_r <= lfsr_next(seed_r);
    raw <= seed_r[4:0];
  end

  always @(negedge sys_clk_i) begin
    for (int i = 3; i > 0; i--) hist[i] = hist[i-1];
    hist[0] = raw;
    if (mon_on) begin
      check("clock_out", {31'h0, exp_out(ctl, hist[3])}, {31'h0, out_o});
      check("divider_ref", {31'h0, ctl[5] ? hist[3][OCC_IN_PLL_B_B] : hist[3][OCC_IN_PLL_A_A]}, {31'h0, ref_o});
    end
  end

  initial begin
    ctl = OCC_CTRL_RST;
    repeat (10) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    check("pdn_reset", 32'h1, {31'h0, pdn_o});
    check("reset_wait_out_ref", {29'h0, 3'h4}, {29'h0, wait_o, out_o, ref_o});
    check("reset_fields", {28'h0, OCC_CTRL_RST[6:5], OCC_CTRL_RST[1:0]}, {28'h0, int_o, pll_o, drv_o});
    check("reset_readdata", 32'h0, rdat);
    bus_op(1'b0, 8'h44, 32'h0, 4'hf, q);
    check("ctrl_reset", {24'h0, OCC_CTRL_RST}, q);
    for (int i = 0; i < 40; i++) begin
      mon_on = 1'b0;
      // No delay offset exists in this block, so integer mode may be drawn freely.
      ctl = (i < 8) ? corner[i] : seed_r[15:8];
      if (ctl[3:2] == OCC_SRC_RSVD) ctl[3] = 1'b0;
      bus_op(1'b1, 8'h44, {seed_r[31:16], 8'h00, ctl}, 4'hf, q);
      bus_op(1'b0, 8'h44, 32'h0, 4'hf, q);
      check("ctrl_read", {24'h0, ctl}, q);
      repeat (6) @(posedge sys_clk_i);
      check("power_down", {31'h0, ctl[7]}, {31'h0, pdn_o});
      check("int_mode", {31'h0, ctl[6]}, {31'h0, int_o});
      check("pll_select", {31'h0, ctl[5]}, {31'h0, pll_o});
      check("drive", {30'h0, ctl[1:0]}, {30'h0, drv_o});
      bus_op(1'b0, 8'h48, 32'h0, 4'hf, q);
      check("status_run", {31'h0, ~ctl[7] & (ctl[3:2] != OCC_SRC_RSVD)}, {31'h0, q[OCC_STAT_RUN]});
      check("status_rest", 32'h0, {q[31:3], ctl[7] & q[OCC_STAT_LVL], q[OCC_STAT_RSVD], 1'b0});
      mon_on = 1'b1;
      repeat (12) @(posedge sys_clk_i);
      $display("test ctrl %h done", ctl);
    end
    mon_on = 1'b0;
    bus_op(1'b1, 8'h44, {24'h0, ~ctl}, 4'h0, q);
    bus_op(1'b0, 8'h44, 32'h0, 4'hf, q);
    check("ctrl_no_lane", {24'h0, ctl}, q);
    bus_op(1'b1, 8'h48, {24'h0, ~ctl}, 4'hf, q);
    bus_op(1'b0, 8'h44, 32'h0, 4'hf, q);
    check("ctrl_status_write", {24'h0, ctl}, q);
    bus_op(1'b0, 8'h80, 32'h0, 4'hf, q);
    check("unmapped_read", 32'h0, q);
    $display("test refusals done");
    @(posedge sys_clk_i);
    rstn_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    check("pdn_mid_reset", 32'h1, {31'h0, pdn_o});
    rstn_i <= 1'b1;
    bus_op(1'b0, 8'h44, 32'h0, 4'hf, q);
    check("ctrl_mid_reset", {24'h0, OCC_CTRL_RST}, q);
    $display("test mid-run reset done");
    complete_run();
  end
endmodule
